// [rtl/icc_consts.vh]
// Constants for the interleave calibration controller.
// Assumes inclusion by bare name from the design files.
`ifndef ICC_CONSTS_VH
`define ICC_CONSTS_VH
`define ICC_ADDR_SOFT_RESET 8'h00
`define ICC_ADDR_CAL_ENABLE 8'h31
`define ICC_ADDR_SYNC_SELECT 8'h77
`define ICC_ADDR_AC_THRESH 8'h40
`define ICC_ADDR_AC_HYST 8'h41
`define ICC_ADDR_TOT_THRESH 8'h42
`define ICC_ADDR_TOT_HYST 8'h43
`define ICC_ADDR_NOTCH_THRESH 8'h44
`define ICC_ADDR_STATUS 8'h45
`define ICC_ADDR_INIT_OFFSET 8'h46
`define ICC_ADDR_INIT_GAIN 8'h47
`define ICC_ADDR_INIT_SKEW 8'h48
`define ICC_ADDR_NOTCH_CTRL 8'h49
`define ICC_ADDR_CUR_OFFSET 8'h4A
`define ICC_ADDR_CUR_GAIN 8'h4B
`define ICC_ADDR_CUR_SKEW 8'h4C
`define ICC_BIT_SOFT_RESET 0
`define ICC_BIT_CAL_ENABLE 0
`define ICC_BIT_SYNC_DIVRST 0
`define ICC_BIT_NOTCH_PD 0
`define ICC_RST_AC_THRESH 8'h20
`define ICC_RST_AC_HYST 8'h04
`define ICC_RST_TOT_THRESH 8'h20
`define ICC_RST_TOT_HYST 8'h04
`define ICC_RST_NOTCH_THRESH 8'h40
`define ICC_RST_INIT 8'h00
`define ICC_POR_CAL_CYCLES 16'h0400
`define ICC_BRIEF_VIOLATION_NS 10000
`define ICC_CLK_PERIOD_NS 5
`define ICC_SETTLE_MS 1000
`endif

// [rtl/icc_power_cmp.v]
// Power comparator with threshold and hysteresis.
// Assumes power, threshold and hysteresis share one scale on ref_clk.
`timescale 1ns/1ps
`default_nettype none
module icc_power_cmp #(
	parameter W = 8
) (
	input wire ref_clk,
	input wire srst,
	input wire [W-1:0] power,
	input wire [W-1:0] thresh,
	input wire [W-1:0] hyst,
	output reg eligible
);
	wire [W:0] upper;
	wire [W:0] lower;
	assign upper = {1'b0, thresh} + {1'b0, hyst};
	assign lower = (thresh > hyst) ? ({1'b0, thresh} - {1'b0, hyst}) : {(W+1){1'b0}};
	always @(posedge ref_clk) begin
		if (srst) begin
			eligible <= 1'b0;
		// RULE_21: hysteresis band compare.
		end else if ({1'b0, power} > upper) begin
			eligible <= 1'b1;
		end else if ({1'b0, power} < lower) begin
			eligible <= 1'b0;
		end
	end
endmodule // icc_power_cmp
`default_nettype wire

// [rtl/icc_calib_ctrl.v]
// Interleave calibration controller: registers, power meter, notch, track/hold engine.
// Assumes a byte register port from the SPI front end and samples from both unit converters.
`timescale 1ns/1ps
`default_nettype none
`include "icc_consts.vh"
// Function
// RULE_01: Calibration engine starts disabled; software enables it by register.
// RULE_02: Running engine estimates and corrects offset, gain and skew continuously.
// RULE_03: Tracking only when filtered input power exceeds its threshold.
// RULE_04: Notch exclusion repeats at every odd multiple of quarter rate.
// RULE_05: Frequency limits scale with sample rate since notch is rate-relative.
// RULE_06: Brief criteria violations are bridged and do not disturb corrections.
// RULE_07: Engine drops to hold automatically when criteria fail.
// RULE_08: Hold keeps the last valid correction values unchanged.
// RULE_09: No drift compensation happens while holding.
// RULE_10: Tracking resumes automatically once criteria are met again.
// RULE_11: Settled flag rises after about one second of tracking.
// RULE_12: AC and total power each compared with own threshold and hysteresis.
// RULE_13: Notch only filters estimation samples; output samples pass untouched.
// RULE_14: Software may power down the notch filter.
// RULE_15: Clearing then setting enable resets the engine to starting values.
// RULE_16: Thresholds, status and starting corrections are readable and writable; status is read-only here, writes to it are ignored.
// RULE_17: Sync pins act as link sync by default, divider reset when selected.
// RULE_18: Systems at divide ratio two use the divider reset for alignment.
// RULE_19: Soft reset bit re-runs the power-on calibration sequence.
// RULE_20: Soft reset bit clears itself when that calibration completes.
// RULE_21: Eligibility rises above threshold plus hysteresis, falls below minus.
module icc_calib_ctrl #(
	parameter DW = 14,
	parameter SETTLE_CYCLES = `ICC_SETTLE_MS * 1000000 / `ICC_CLK_PERIOD_NS,
	parameter POR_CYCLES = `ICC_POR_CAL_CYCLES
) (
	input wire ref_clk,
	input wire srst,
	input wire reg_wr,
	input wire reg_rd,
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wdata,
	output reg [7:0] reg_rdata,
	input wire [DW-1:0] sample_a,
	input wire [DW-1:0] sample_b,
	output reg [DW-1:0] out_a,
	output reg [DW-1:0] out_b,
	input wire sync_input_pos,
	input wire sync_input_neg,
	output reg link_sync_n,
	output reg divider_reset,
	output reg [7:0] corr_offset,
	output reg [7:0] corr_gain,
	output reg [7:0] corr_skew,
	output reg tracking,
	output reg settled,
	output reg por_cal_busy
);
	localparam ST_IDLE = 2'd0;
	localparam ST_POR = 2'd1;
	localparam ST_RUN = 2'd2;
	localparam [15:0] BRIEF_CYCLES = `ICC_BRIEF_VIOLATION_NS / `ICC_CLK_PERIOD_NS;
	reg [1:0] state;
	reg [1:0] next_state;
	reg soft_reset;
	reg cal_enable;
	reg sync_divrst;
	reg notch_pd;
	reg [7:0] ac_thresh;
	reg [7:0] ac_hyst;
	reg [7:0] tot_thresh;
	reg [7:0] tot_hyst;
	reg [7:0] notch_thresh;
	reg [7:0] init_offset;
	reg [7:0] init_gain;
	reg [7:0] init_skew;
	reg [15:0] por_cnt;
	reg [15:0] brief_cnt;
	reg [31:0] settle_cnt;
	reg [DW-1:0] est_a;
	reg [DW-1:0] est_b;
	reg [DW-1:0] est_a_d;
	reg [DW-1:0] est_b_d;
	reg [7:0] ac_pow;
	reg [7:0] tot_pow;
	reg [7:0] notch_pow;
	reg notch_hit;
	reg sync_p_m;
	reg sync_p_s;
	reg sync_n_m;
	reg sync_n_s;
	reg cal_enable_d;
	wire ac_ok;
	wire tot_ok;
	wire criteria_ok;
	wire track_now;
	function [7:0] mag8;
		input [DW-1:0] s;
		reg [DW-1:0] m;
		begin
			m = s[DW-1] ? (~s + 1'b1) : s;
			mag8 = m[DW-2 -: 8];
		end
	endfunction
	function [7:0] avg8;
		input [7:0] acc;
		input [7:0] x;
		begin
			avg8 = acc - (acc >> 4) + (x >> 4);
		end
	endfunction
	function [7:0] step8;
		input [7:0] v;
		input up;
		begin
			step8 = up ? ((v == 8'hFF) ? v : v + 8'h01) : ((v == 8'h00) ? v : v - 8'h01);
		end
	endfunction
	function [DW-1:0] half_sum;
		input [DW-1:0] x;
		input [DW-1:0] y;
		reg [DW:0] s;
		begin
			s = {x[DW-1], x} + {y[DW-1], y};
			half_sum = s[DW:1];
		end
	endfunction
	// RULE_12: AC power comparator.
	icc_power_cmp #(.W(8)) u_ac_cmp (
		.ref_clk(ref_clk),
		.srst(srst),
		.power(ac_pow),
		.thresh(ac_thresh),
		.hyst(ac_hyst),
		.eligible(ac_ok)
	);
	// RULE_12: Total power comparator.
	icc_power_cmp #(.W(8)) u_tot_cmp (
		.ref_clk(ref_clk),
		.srst(srst),
		.power(tot_pow),
		.thresh(tot_thresh),
		.hyst(tot_hyst),
		.eligible(tot_ok)
	);
	// RULE_03: Both meters must qualify.
	assign criteria_ok = ac_ok && tot_ok;
	// RULE_06: Bridge brief violations.
	assign track_now = criteria_ok || (brief_cnt != 16'h0000);
	always @* begin
		next_state = state;
		case (state)
			ST_IDLE: begin
				if (soft_reset) begin
					next_state = ST_POR;
				end else if (cal_enable) begin
					next_state = ST_RUN;
				end
			end
			ST_POR: begin
				if (por_cnt == 16'h0000) begin
					next_state = ST_IDLE;
				end
			end
			ST_RUN: begin
				if (soft_reset) begin
					next_state = ST_POR;
				end else if (!cal_enable) begin
					next_state = ST_IDLE;
				end
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
	end
	always @(posedge ref_clk) begin
		if (srst) begin
			sync_p_m <= 1'b0;
			sync_p_s <= 1'b0;
			sync_n_m <= 1'b1;
			sync_n_s <= 1'b1;
			link_sync_n <= 1'b1;
			divider_reset <= 1'b0;
		end else begin
			sync_p_m <= sync_input_pos;
			sync_p_s <= sync_p_m;
			sync_n_m <= sync_input_neg;
			sync_n_s <= sync_n_m;
			// RULE_17: Route the sync pair by function select.
			link_sync_n <= sync_divrst ? 1'b1 : !(sync_p_s && !sync_n_s);
			divider_reset <= sync_divrst && sync_p_s && !sync_n_s;
		end
	end
	always @(posedge ref_clk) begin
		if (srst) begin
			out_a <= {DW{1'b0}};
			out_b <= {DW{1'b0}};
			est_a <= {DW{1'b0}};
			est_b <= {DW{1'b0}};
			est_a_d <= {DW{1'b0}};
			est_b_d <= {DW{1'b0}};
			ac_pow <= 8'h00;
			tot_pow <= 8'h00;
			notch_pow <= 8'h00;
			notch_hit <= 1'b0;
		end else begin
			// RULE_13: Output samples bypass the notch.
			out_a <= sample_a;
			out_b <= sample_b;
			est_a_d <= out_a;
			est_b_d <= out_b;
			// RULE_04: Two-sample comb nulls odd multiples of quarter rate.
			// RULE_14: Powered-down notch passes samples straight.
			est_a <= notch_pd ? sample_a : half_sum(sample_a, est_a_d);
			est_b <= notch_pd ? sample_b : half_sum(sample_b, est_b_d);
			// RULE_05: Rate-relative filtering scales the band with the sample rate.
			tot_pow <= avg8(tot_pow, mag8(est_a));
			ac_pow <= avg8(ac_pow, mag8(est_a - est_b));
			notch_pow <= avg8(notch_pow, mag8(sample_a - est_a));
			notch_hit <= notch_pow > notch_thresh;
		end
	end
	always @(posedge ref_clk) begin
		if (srst) begin
			state <= ST_IDLE;
			por_cnt <= 16'h0000;
			brief_cnt <= 16'h0000;
			settle_cnt <= 32'h00000000;
			cal_enable_d <= 1'b0;
			tracking <= 1'b0;
			settled <= 1'b0;
			por_cal_busy <= 1'b0;
			corr_offset <= `ICC_RST_INIT;
			corr_gain <= `ICC_RST_INIT;
			corr_skew <= `ICC_RST_INIT;
		end else begin
			state <= next_state;
			cal_enable_d <= cal_enable;
			por_cal_busy <= (next_state == ST_POR);
			// RULE_19: Load the power-on calibration timer.
			if (state != ST_POR && next_state == ST_POR) begin
				por_cnt <= POR_CYCLES[15:0];
			end else if (por_cnt != 16'h0000) begin
				por_cnt <= por_cnt - 16'h0001;
			end
			if (criteria_ok) begin
				brief_cnt <= BRIEF_CYCLES;
			end else if (brief_cnt != 16'h0000) begin
				brief_cnt <= brief_cnt - 16'h0001;
			end
			// RULE_07: Hold is entered without software.
			// RULE_10: Tracking resumes without software.
			tracking <= (state == ST_RUN) && track_now;
			// RULE_11: Count tracked time toward settled.
			if (state != ST_RUN) begin
				settle_cnt <= 32'h00000000;
				settled <= 1'b0;
			end else if (tracking && settle_cnt < SETTLE_CYCLES) begin
				settle_cnt <= settle_cnt + 32'h00000001;
			end else if (settle_cnt >= SETTLE_CYCLES) begin
				settled <= 1'b1;
			end
			// RULE_15: Enable rising edge restarts from starting values.
			if (state != ST_RUN || (cal_enable && !cal_enable_d)) begin
				corr_offset <= init_offset;
				corr_gain <= init_gain;
				corr_skew <= init_skew;
			// RULE_02: Track mismatch from sample statistics.
			// RULE_08: Updates only while tracking, otherwise frozen.
			// RULE_09: No drift updates while holding.
			end else if (tracking) begin
				corr_offset <= step8(corr_offset, est_a[DW-1] ^ est_b[DW-1]);
				corr_gain <= step8(corr_gain, mag8(est_a) > mag8(est_b));
				corr_skew <= step8(corr_skew, mag8(est_a - est_b_d) > mag8(est_b - est_a));
			end
		end
	end
	always @(posedge ref_clk) begin
		if (srst) begin
			// RULE_01: Engine disabled after reset.
			cal_enable <= 1'b0;
			soft_reset <= 1'b0;
			sync_divrst <= 1'b0;
			notch_pd <= 1'b0;
			ac_thresh <= `ICC_RST_AC_THRESH;
			ac_hyst <= `ICC_RST_AC_HYST;
			tot_thresh <= `ICC_RST_TOT_THRESH;
			tot_hyst <= `ICC_RST_TOT_HYST;
			notch_thresh <= `ICC_RST_NOTCH_THRESH;
			init_offset <= `ICC_RST_INIT;
			init_gain <= `ICC_RST_INIT;
			init_skew <= `ICC_RST_INIT;
			reg_rdata <= 8'h00;
		end else begin
			// RULE_20: Self-clear when calibration ends; a new write wins.
			if (state == ST_POR && por_cnt == 16'h0001) begin
				soft_reset <= 1'b0;
			end
			if (reg_wr) begin
				case (reg_addr)
					// RULE_19: Write one to start soft reset.
					`ICC_ADDR_SOFT_RESET: begin
						if (reg_wdata[`ICC_BIT_SOFT_RESET]) begin
							soft_reset <= 1'b1;
						end
					end
					`ICC_ADDR_CAL_ENABLE: cal_enable <= reg_wdata[`ICC_BIT_CAL_ENABLE];
					`ICC_ADDR_SYNC_SELECT: sync_divrst <= reg_wdata[`ICC_BIT_SYNC_DIVRST];
					`ICC_ADDR_NOTCH_CTRL: notch_pd <= reg_wdata[`ICC_BIT_NOTCH_PD];
					`ICC_ADDR_AC_THRESH: ac_thresh <= reg_wdata;
					`ICC_ADDR_AC_HYST: ac_hyst <= reg_wdata;
					`ICC_ADDR_TOT_THRESH: tot_thresh <= reg_wdata;
					`ICC_ADDR_TOT_HYST: tot_hyst <= reg_wdata;
					`ICC_ADDR_NOTCH_THRESH: notch_thresh <= reg_wdata;
					`ICC_ADDR_INIT_OFFSET: init_offset <= reg_wdata;
					`ICC_ADDR_INIT_GAIN: init_gain <= reg_wdata;
					`ICC_ADDR_INIT_SKEW: init_skew <= reg_wdata;
					default: begin
					end
				endcase
			end
			// RULE_16: Register readback.
			if (reg_rd) begin
				case (reg_addr)
					`ICC_ADDR_SOFT_RESET: reg_rdata <= {7'h00, soft_reset};
					`ICC_ADDR_CAL_ENABLE: reg_rdata <= {7'h00, cal_enable};
					`ICC_ADDR_SYNC_SELECT: reg_rdata <= {7'h00, sync_divrst};
					`ICC_ADDR_NOTCH_CTRL: reg_rdata <= {7'h00, notch_pd};
					`ICC_ADDR_AC_THRESH: reg_rdata <= ac_thresh;
					`ICC_ADDR_AC_HYST: reg_rdata <= ac_hyst;
					`ICC_ADDR_TOT_THRESH: reg_rdata <= tot_thresh;
					`ICC_ADDR_TOT_HYST: reg_rdata <= tot_hyst;
					`ICC_ADDR_NOTCH_THRESH: reg_rdata <= notch_thresh;
					`ICC_ADDR_STATUS: reg_rdata <= {2'b00, settled, tracking,
						notch_hit, tot_ok, ac_ok, por_cal_busy};
					`ICC_ADDR_INIT_OFFSET: reg_rdata <= init_offset;
					`ICC_ADDR_INIT_GAIN: reg_rdata <= init_gain;
					`ICC_ADDR_INIT_SKEW: reg_rdata <= init_skew;
					`ICC_ADDR_CUR_OFFSET: reg_rdata <= corr_offset;
					`ICC_ADDR_CUR_GAIN: reg_rdata <= corr_gain;
					`ICC_ADDR_CUR_SKEW: reg_rdata <= corr_skew;
					default: reg_rdata <= 8'h00;
				endcase
			end
		end
	end
endmodule // icc_calib_ctrl
`default_nettype wire

// [verification/icc_calib_checker.sv]
// Port checker for the calibration controller.
// Assumes a bind onto icc_calib_ctrl with matching parameters.
`timescale 1ns/1ps
`default_nettype none
module icc_calib_checker #(
	parameter int DW = 14,
	parameter int POR_CYCLES = 8
) (
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	input wire logic [DW-1:0] sample_a,
	input wire logic [DW-1:0] sample_b,
	input wire logic [DW-1:0] out_a,
	input wire logic [DW-1:0] out_b,
	input wire logic sync_input_pos,
	input wire logic link_sync_n,
	input wire logic divider_reset,
	input wire logic [7:0] corr_offset,
	input wire logic tracking,
	input wire logic settled,
	input wire logic por_cal_busy
);
	localparam int BUSY_MAX = POR_CYCLES + 4;
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (srst);
	AST_RST_IDLE: assert property ($past(srst) |-> !tracking && !settled && !por_cal_busy)
		else $error("Engine active right after reset.");
	AST_OUT_PASS: assert property (!$past(srst) |-> out_a == $past(sample_a)
		&& out_b == $past(sample_b))
		else $error("Output samples altered.");
	AST_SYNC_IDLE: assert property ((!sync_input_pos) [*5]
		|-> link_sync_n && !divider_reset)
		else $error("Sync outputs active with idle pins.");
	AST_HOLD_STABLE: assert property (!$past(tracking) && !$past(tracking, 2)
		&& !$past(reg_wr) && !$past(reg_wr, 2) |-> $stable(corr_offset))
		else $error("Correction moved while holding.");
	AST_STEP_ONE: assert property ($past(tracking) && tracking && !$past(reg_wr)
		&& !$past(reg_wr, 2) |-> 8'(corr_offset - $past(corr_offset) + 8'h01) <= 8'h02)
		else $error("Correction step larger than one.");
	AST_SOFT_BUSY: assert property (reg_wr && reg_addr == 8'h00 && reg_wdata[0]
		|-> ##[1:3] por_cal_busy)
		else $error("Soft reset did not start calibration.");
	AST_BUSY_END: assert property ($rose(por_cal_busy) |-> ##[1:BUSY_MAX] !por_cal_busy)
		else $error("Calibration did not finish in time.");
	AST_DISABLE_HOLD: assert property (reg_wr && reg_addr == 8'h31 && !reg_wdata[0]
		|-> ##[1:3] !tracking)
		else $error("Tracking kept after disable.");
	AST_SETTLE_TRK: assert property ($rose(settled) |-> $past(tracking))
		else $error("Settled rose without tracking.");
	AST_RSVD_READ: assert property (reg_rd && reg_addr == 8'h31
		|=> reg_rdata[7:1] == 7'h00)
		else $error("Reserved enable bits read nonzero.");
	cover property (tracking ##1 !tracking);
	cover property ($rose(por_cal_busy));
	cover property ($rose(settled));
endmodule // icc_calib_checker
bind icc_calib_ctrl icc_calib_checker #(.DW(DW), .POR_CYCLES(POR_CYCLES))
	icc_calib_checker_inst (.*);
`default_nettype wire

// [verification/icc_sys_ctrl_model.sv]
// Stand-in for the system controller driving the sync pin pair.
// Assumes the bench changes sync_req just after a rising edge.
`timescale 1ns/1ps
`default_nettype none
module icc_sys_ctrl_model (
	input wire logic ref_clk,
	input wire logic sync_req,
	output logic sync_input_pos,
	output logic sync_input_neg
);
	always @(posedge ref_clk) begin
		sync_input_pos <= sync_req;
		sync_input_neg <= !sync_req;
	end
endmodule // icc_sys_ctrl_model
`default_nettype wire

// [verification/testbench.sv]
// Self-checking bench for the calibration controller.
// Assumes a 200 MHz clock and the sync pin stand-in model.
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic ref_clk, srst, reg_wr, reg_rd, loud, sync_req, ph;
	logic [7:0] reg_addr, reg_wdata;
	logic [13:0] sample_a, sample_b;
	wire [7:0] reg_rdata, corr_offset, corr_gain, corr_skew;
	wire [13:0] out_a, out_b;
	wire sync_input_pos, sync_input_neg, link_sync_n, divider_reset;
	wire tracking, settled, por_cal_busy;
	logic [7:0] snap;
	logic [7:0] ra [8] = '{8'h31, 8'h40, 8'h41, 8'h42, 8'h43, 8'h44, 8'h46, 8'h10};
	logic [7:0] rv [8] = '{8'h00, 8'h20, 8'h04, 8'h20, 8'h04, 8'h40, 8'h00, 8'h00};
	int errors, cmp_count;
	icc_calib_ctrl #(.SETTLE_CYCLES(100), .POR_CYCLES(8)) icc_calib_ctrl_inst (.*);
	icc_sys_ctrl_model icc_sys_ctrl_model_inst (.*);
	initial begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) begin
		ph <= !ph;
		sample_a <= loud ? (ph ? 14'h1800 : 14'h2800) : 14'h0000;
		sample_b <= loud ? (ph ? 14'h2800 : 14'h1800) : 14'h0000;
	end
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge ref_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata, exp);
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	task automatic report_and_stop;
		$display("Counts: compares=%0d mismatches=%0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic wait_on(input int sel, input logic v, input int n);
		logic s;
		for (int i = 0; i < n; i++) begin
			@(posedge ref_clk);
			#1 s = sel == 0 ? tracking : (sel == 1 ? settled : por_cal_busy);
			if (s === v)
				return;
		end
		chk({7'h00, s}, {7'h00, v});
		report_and_stop();
	endtask
	initial begin
		srst = 1'b1;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		loud = 1'b1;
		sync_req = 1'b0;
		ph = 1'b0;
		sample_a = 14'h0000;
		sample_b = 14'h0000;
		errors = 0;
		cmp_count = 0;
		repeat (16) @(posedge ref_clk);
		srst <= 1'b0;
		foreach (ra[i]) rd(ra[i], rv[i]);
		chk({7'h00, tracking}, 8'h00);
		$display("Test reset values done");
		wr(8'h46, 8'h5A);
		wr(8'h47, 8'h33);
		wr(8'h48, 8'h44);
		wr(8'h49, 8'h01);
		rd(8'h46, 8'h5A);
		rd(8'h49, 8'h01);
		wr(8'h49, 8'h00);
		rd(8'h4A, 8'h5A);
		rd(8'h4B, 8'h33);
		rd(8'h4C, 8'h44);
		$display("Test register access done");
		wr(8'h31, 8'h01);
		wait_on(0, 1'b1, 500);
		wait_on(1, 1'b1, 400);
		chk({5'h00, corr_offset != 8'h5A, corr_gain != 8'h33, corr_skew != 8'h44}, 8'h07);
		$display("Test tracking done");
		@(posedge ref_clk) loud <= 1'b0;
		cyc(1500);
		chk({7'h00, tracking}, 8'h01);
		wait_on(0, 1'b0, 4000);
		snap = corr_offset;
		cyc(50);
		chk(corr_offset, snap);
		@(posedge ref_clk) loud <= 1'b1;
		wait_on(0, 1'b1, 4000);
		$display("Test hold done");
		wr(8'h31, 8'h00);
		wait_on(0, 1'b0, 10);
		cyc(4);
		chk(corr_offset, 8'h5A);
		chk(corr_gain, 8'h33);
		chk(corr_skew, 8'h44);
		wr(8'h31, 8'h01);
		$display("Test engine reset done");
		wr(8'h00, 8'h01);
		rd(8'h00, 8'h01);
		wait_on(2, 1'b0, 40);
		rd(8'h00, 8'h00);
		wait_on(0, 1'b1, 500);
		$display("Test soft reset done");
		@(posedge ref_clk) sync_req <= 1'b1;
		cyc(6);
		chk({6'h00, link_sync_n, divider_reset}, 8'h00);
		wr(8'h77, 8'h01);
		cyc(6);
		chk({6'h00, link_sync_n, divider_reset}, 8'h03);
		rd(8'h77, 8'h01);
		@(posedge ref_clk) sync_req <= 1'b0;
		cyc(6);
		chk({6'h00, link_sync_n, divider_reset}, 8'h02);
		$display("Test sync select done");
		report_and_stop();
	end
endmodule // testbench
`default_nettype wire
